// File: rtl/ramp_fault_regs.sv
// Command-addressed ramp timing settings and global fault summaries.
// Assumes a command layer handing over one decoded transaction per cycle;
// the ramp generator and detailed status registers live outside.
`timescale 1ns/100ps
module ramp_fault_regs #(
    parameter int NOUT = 2
) (
    input  wire logic                              clock_i,
    input  wire logic                              rst_i,
    input  wire logic                              cmd_valid_i,
    input  wire logic                              cmd_write_i,
    input  wire logic [7:0]                        cmd_code_i,
    input  wire logic [$clog2(NOUT)-1:0]           cmd_page_i,
    input  wire logic [15:0]                       cmd_wdata_i,
    input  wire logic [NOUT-1:0][7:0]              vout_status_i,
    input  wire logic [NOUT-1:0][7:0]              iout_status_i,
    input  wire logic [7:0]                        input_status_i,
    input  wire logic [7:0]                        temp_status_i,
    input  wire logic [7:0]                        cml_ext_i,
    input  wire logic [7:0]                        mfr_status_i,
    input  wire logic [NOUT-1:0]                   power_off_i,
    input  wire logic [NOUT-1:0]                   power_good_i,
    input  wire logic                              other_event_i,
    output logic                                   rd_valid_o,
    output logic      [15:0]                       rd_data_o,
    output logic                                   nak_o,
    output logic                                   commit_o,
    output logic      [NOUT-1:0][15:0]             rise_time_o,
    output logic      [NOUT-1:0][15:0]             off_delay_o,
    output logic      [NOUT-1:0][15:0]             fall_time_o,
    output logic      [7:0]                        cml_status_o,
    output logic      [7:0]                        status_byte_o,
    output logic      [15:0]                       status_word_o,
    output logic                                   alert_o,
    output logic                                   temp_warn_o
);
    import ramp_fault_pkg::*;

    localparam int PAGE_W = $clog2(NOUT);

    generate
        if (NOUT < 2 || NOUT > 4) begin : g_bad_nout
            $error("ramp_fault_regs: NOUT must be 2 to 4");
        end
    endgenerate

    // Code recognised at all, in either direction
    function automatic logic known_code(input logic [7:0] code);
        return code inside {CODE_CLEAR_FAULTS, CODE_RISE, CODE_OFF_DELAY,
                            CODE_FALL, CODE_SUM_SHORT, CODE_SUM_FULL,
                            CODE_COMMIT};
    endfunction : known_code

    // Send-only commands carry no data to read back
    function automatic logic send_only(input logic [7:0] code);
        return code inside {CODE_CLEAR_FAULTS, CODE_COMMIT};
    endfunction : send_only

    function automatic logic paged_code(input logic [7:0] code);
        return code inside {CODE_RISE, CODE_OFF_DELAY, CODE_FALL};
    endfunction : paged_code

    function automatic logic [15:0] limit_of(input logic [7:0] code);
        return (code == CODE_OFF_DELAY) ? DELAY_MAX : RAMP_MAX;
    endfunction : limit_of

    logic                  bad_cmd;
    logic                  bad_data;
    logic                  wr_rise;
    logic                  wr_delay;
    logic                  wr_fall;
    logic                  commit_fire;
    logic                  clear_fire;
    logic                  rd_fire;
    logic                  cml_bad_cmd;
    logic                  cml_bad_data;
    logic [NOUT-1:0][15:0] rise_pending;
    logic [NOUT-1:0][15:0] delay_pending;
    logic [NOUT-1:0][15:0] fall_pending;
    logic [15:0]           next_rd_data;

    // Transaction decode
    always_comb begin
        bad_cmd     = 1'b0;
        bad_data    = 1'b0;
        wr_rise     = 1'b0;
        wr_delay    = 1'b0;
        wr_fall     = 1'b0;
        commit_fire = 1'b0;
        clear_fire  = 1'b0;
        rd_fire     = 1'b0;
        if (cmd_valid_i) begin
            if (!known_code(cmd_code_i) ||
                (!cmd_write_i && send_only(cmd_code_i))) begin
                bad_cmd = 1'b1;
            end else if (paged_code(cmd_code_i) &&
                         32'(cmd_page_i) >= NOUT) begin
                bad_data = 1'b1;
            end else if (!cmd_write_i) begin
                rd_fire = 1'b1;
            end else if (paged_code(cmd_code_i) &&
                         cmd_wdata_i > limit_of(cmd_code_i)) begin
                // Out-of-range settings never reach the ramp generator
                bad_data = 1'b1;
            end else begin
                unique case (cmd_code_i)
                    CODE_RISE:         wr_rise     = 1'b1;
                    CODE_OFF_DELAY:    wr_delay    = 1'b1;
                    CODE_FALL:         wr_fall     = 1'b1;
                    CODE_COMMIT:       commit_fire = 1'b1;
                    CODE_CLEAR_FAULTS: clear_fire  = 1'b1;
                    default:           ;
                endcase
            end
        end
    end

    ramp_setting_store #(
        .NOUT      (NOUT),
        .PAGE_W    (PAGE_W),
        .RESET_VAL (RISE_RESET)
    ) u_rise (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .wr_i      (wr_rise),
        .page_i    (cmd_page_i),
        .wdata_i   (cmd_wdata_i),
        .commit_i  (commit_fire),
        .direct_i  (1'b0),
        .pending_o (rise_pending),
        .active_o  (rise_time_o)
    );

    // The turn-off delay has no commit step and applies at once
    ramp_setting_store #(
        .NOUT      (NOUT),
        .PAGE_W    (PAGE_W),
        .RESET_VAL (DELAY_RESET)
    ) u_delay (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .wr_i      (wr_delay),
        .page_i    (cmd_page_i),
        .wdata_i   (cmd_wdata_i),
        .commit_i  (commit_fire),
        .direct_i  (1'b1),
        .pending_o (delay_pending),
        .active_o  (off_delay_o)
    );

    ramp_setting_store #(
        .NOUT      (NOUT),
        .PAGE_W    (PAGE_W),
        .RESET_VAL (FALL_RESET)
    ) u_fall (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .wr_i      (wr_fall),
        .page_i    (cmd_page_i),
        .wdata_i   (cmd_wdata_i),
        .commit_i  (commit_fire),
        .direct_i  (1'b0),
        .pending_o (fall_pending),
        .active_o  (fall_time_o)
    );

    // Own communication errors; a new error beats a same-cycle clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cml_bad_cmd  <= 1'b0;
            cml_bad_data <= 1'b0;
        end else begin
            cml_bad_cmd  <= bad_cmd | (cml_bad_cmd & ~clear_fire);
            cml_bad_data <= bad_data | (cml_bad_data & ~clear_fire);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cml_status_o <= 8'h00;
        end else begin
            cml_status_o <= cml_ext_i;
            cml_status_o[CML_BAD_CMD]  <= cml_bad_cmd |
                                          cml_ext_i[CML_BAD_CMD];
            cml_status_o[CML_BAD_DATA] <= cml_bad_data |
                                          cml_ext_i[CML_BAD_DATA];
        end
    end

    fault_summary_merge #(
        .NOUT           (NOUT)
    ) u_merge (
        .clock_i        (clock_i),
        .rst_i          (rst_i),
        .vout_status_i  (vout_status_i),
        .iout_status_i  (iout_status_i),
        .input_status_i (input_status_i),
        .temp_status_i  (temp_status_i),
        .cml_status_i   (cml_status_o),
        .mfr_status_i   (mfr_status_i),
        .power_off_i    (power_off_i),
        .power_good_i   (power_good_i),
        .other_event_i  (other_event_i),
        .status_byte_o  (status_byte_o),
        .status_word_o  (status_word_o)
    );

    // Read-back shows pending settings, so a host can verify before commit
    always_comb begin
        next_rd_data = 16'h0000;
        unique case (cmd_code_i)
            CODE_RISE:      next_rd_data = rise_pending[cmd_page_i];
            CODE_OFF_DELAY: next_rd_data = delay_pending[cmd_page_i];
            CODE_FALL:      next_rd_data = fall_pending[cmd_page_i];
            CODE_SUM_SHORT: next_rd_data = {8'h00, status_byte_o};
            CODE_SUM_FULL:  next_rd_data = status_word_o;
            default:        next_rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= 16'h0000;
        end else begin
            rd_valid_o <= rd_fire;
            if (rd_fire) begin
                rd_data_o <= next_rd_data;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            nak_o    <= 1'b0;
            commit_o <= 1'b0;
        end else begin
            nak_o    <= bad_cmd | bad_data;
            commit_o <= commit_fire;
        end
    end

    // Off alone is normal when disabled, so it raises no alert
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            alert_o     <= 1'b0;
            temp_warn_o <= 1'b0;
        end else begin
            alert_o     <= |(status_word_o & ~(16'h0001 << SB_OFF));
            temp_warn_o <= temp_status_i[DET_OT_WARN];
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence s_write(logic [7:0] code);
        cmd_valid_i && cmd_write_i && cmd_code_i == code &&
        32'(cmd_page_i) < NOUT && cmd_wdata_i <= limit_of(code);
    endsequence

    sequence s_hot2;
        temp_status_i[DET_OT_WARN] ##1 temp_status_i[DET_OT_WARN];
    endsequence

    a_rise_waits: assert property (
        !commit_fire |=> $stable(rise_time_o))
        else $error("rise time changed without commit");

    a_commit_applies: assert property (
        commit_fire |=> fall_time_o == $past(fall_pending) && commit_o)
        else $error("commit did not apply fall time");

    a_rise_store: assert property (
        s_write(CODE_RISE) |=> rise_pending[$past(cmd_page_i)]
                               == $past(cmd_wdata_i))
        else $error("rise write not stored");

    a_range_refused: assert property (
        cmd_valid_i && cmd_write_i && cmd_code_i == CODE_OFF_DELAY &&
        cmd_wdata_i > DELAY_MAX |=> nak_o && $stable(off_delay_o))
        else $error("out-of-range delay accepted");

    a_byte_unused: assert property (
        !status_byte_o[SB_UNUSED] &&
        status_word_o[SW_UNUSED_HI:SW_UNUSED_LO] == 4'h0)
        else $error("unused summary bits set");

    a_word_low: assert property (
        status_word_o[7:0] == status_byte_o)
        else $error("full summary low byte differs");

    a_off_bit: assert property (
        |power_off_i |=> status_byte_o[SB_OFF])
        else $error("off bit not set");

    a_ov_merge: assert property (
        vout_status_i[NOUT-1][DET_VOUT_OV] |=>
        status_byte_o[SB_VOUT_OV] && status_word_o[SW_VOUT])
        else $error("overvoltage not summarised");

    a_pg_bit: assert property (
        !power_good_i[0] |=> status_word_o[SW_PG_N])
        else $error("power-good negation not shown");

    a_temp_alert: assert property (
        s_hot2 |=> alert_o && temp_warn_o && status_byte_o[SB_TEMP])
        else $error("temperature warning not signalled");

    a_bad_code: assert property (
        cmd_valid_i && !known_code(cmd_code_i) |=>
        nak_o ##1 cml_status_o[CML_BAD_CMD] ##1 status_byte_o[SB_CML])
        else $error("invalid command not logged");

    a_ro_ignored: assert property (
        cmd_valid_i && cmd_write_i && cmd_code_i == CODE_SUM_FULL |=>
        !nak_o && !rd_valid_o)
        else $error("summary write not ignored");
endmodule : ramp_fault_regs

// File: rtl/ramp_fault_pkg.sv
// Constants for the ramp timing and fault summary register block.
// Assumes a command layer that delivers whole decoded transactions.
package ramp_fault_pkg;
    localparam logic [7:0]  CODE_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0]  CODE_RISE         = 8'h61;
    localparam logic [7:0]  CODE_OFF_DELAY    = 8'h64;
    localparam logic [7:0]  CODE_FALL         = 8'h65;
    localparam logic [7:0]  CODE_SUM_SHORT    = 8'h78;
    localparam logic [7:0]  CODE_SUM_FULL     = 8'h79;
    localparam logic [7:0]  CODE_COMMIT       = 8'hE7;

    localparam logic [15:0] RISE_RESET  = 16'h01F4;
    localparam logic [15:0] DELAY_RESET = 16'h0000;
    localparam logic [15:0] FALL_RESET  = 16'h01F4;

    localparam int          RAMP_MAX_US    = 10000;
    localparam int          DELAY_MAX_US   = 100000;
    localparam int          DELAY_UNIT_US  = 10;
    localparam logic [15:0] RAMP_MAX       = 16'(RAMP_MAX_US);
    localparam logic [15:0] DELAY_MAX      =
        16'(DELAY_MAX_US / DELAY_UNIT_US);

    localparam int SB_UNUSED  = 7;
    localparam int SB_OFF     = 6;
    localparam int SB_VOUT_OV = 5;
    localparam int SB_IOUT_OC = 4;
    localparam int SB_VIN_UV  = 3;
    localparam int SB_TEMP    = 2;
    localparam int SB_CML     = 1;
    localparam int SB_OTHER   = 0;
    localparam int SW_VOUT    = 15;
    localparam int SW_IOUT    = 14;
    localparam int SW_INPUT   = 13;
    localparam int SW_MFR     = 12;
    localparam int SW_PG_N    = 11;
    localparam int SW_UNUSED_HI = 10;
    localparam int SW_UNUSED_LO = 7;

    localparam int DET_VOUT_OV  = 7;
    localparam int DET_IOUT_OC  = 7;
    localparam int DET_VIN_UV   = 4;
    localparam int DET_OT_WARN  = 6;
    localparam int CML_BAD_CMD  = 7;
    localparam int CML_BAD_DATA = 6;
endpackage : ramp_fault_pkg

// File: rtl/ramp_setting_store.sv
// Per-output ramp setting with a pending copy and an applied copy.
// Assumes writes arrive already range-checked by the command decoder.
`timescale 1ns/100ps
module ramp_setting_store #(
    parameter int          NOUT      = 2,
    parameter int          PAGE_W    = 1,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_i,
    input  wire logic                        wr_i,
    input  wire logic [PAGE_W-1:0]           page_i,
    input  wire logic [15:0]                 wdata_i,
    input  wire logic                        commit_i,
    input  wire logic                        direct_i,
    output logic      [NOUT-1:0][15:0]       pending_o,
    output logic      [NOUT-1:0][15:0]       active_o
);
    genvar g;
    generate
        for (g = 0; g < NOUT; g++) begin : g_out
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    pending_o[g] <= RESET_VAL;
                end else if (wr_i && page_i == PAGE_W'(g)) begin
                    pending_o[g] <= wdata_i;
                end
            end
            // Direct settings bypass commit; others wait for it
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    active_o[g] <= RESET_VAL;
                end else if (direct_i && wr_i && page_i == PAGE_W'(g)) begin
                    active_o[g] <= wdata_i;
                end else if (commit_i) begin
                    active_o[g] <= pending_o[g];
                end
            end
        end
    endgenerate
endmodule : ramp_setting_store

// File: rtl/fault_summary_merge.sv
// Merges detailed status of all NOUT outputs into the two summaries.
// Assumes detailed status bits are levels held by their owners.
`timescale 1ns/100ps
module fault_summary_merge
    import ramp_fault_pkg::*;
#(
    parameter int NOUT = 2
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    input  wire logic [NOUT-1:0][7:0]  vout_status_i,
    input  wire logic [NOUT-1:0][7:0]  iout_status_i,
    input  wire logic [7:0]            input_status_i,
    input  wire logic [7:0]            temp_status_i,
    input  wire logic [7:0]            cml_status_i,
    input  wire logic [7:0]            mfr_status_i,
    input  wire logic [NOUT-1:0]       power_off_i,
    input  wire logic [NOUT-1:0]       power_good_i,
    input  wire logic                  other_event_i,
    output logic      [7:0]            status_byte_o,
    output logic      [15:0]           status_word_o
);
    logic [7:0]  next_byte;
    logic [15:0] next_word;

    always_comb begin
        next_byte = 8'h00;
        next_word = 16'h0000;
        for (int i = 0; i < NOUT; i++) begin
            next_byte[SB_VOUT_OV] |= vout_status_i[i][DET_VOUT_OV];
            next_byte[SB_IOUT_OC] |= iout_status_i[i][DET_IOUT_OC];
            next_word[SW_VOUT]    |= |vout_status_i[i];
            next_word[SW_IOUT]    |= |iout_status_i[i];
        end
        next_byte[SB_OFF]    = |power_off_i;
        next_byte[SB_VIN_UV] = input_status_i[DET_VIN_UV];
        next_byte[SB_TEMP]   = |temp_status_i;
        next_byte[SB_CML]    = |cml_status_i;
        next_byte[SB_OTHER]  = other_event_i;
        next_word[7:0]       = next_byte;
        next_word[SW_INPUT]  = |input_status_i;
        next_word[SW_MFR]    = |mfr_status_i;
        next_word[SW_PG_N]   = ~&power_good_i;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_byte_o <= 8'h00;
            status_word_o <= 16'h0000;
        end else begin
            status_byte_o <= next_byte;
            status_word_o <= next_word;
        end
    end
endmodule : fault_summary_merge

// File: testbench/host_cmd_model.sv
// Host-side command source for the ramp timing register block.
// Assumes calls only at a falling clock edge; one transaction per cycle.
`timescale 1ns/100ps
module host_cmd_model
    import ramp_fault_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rd_valid_i,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        nak_i,
    output logic             cmd_valid_o,
    output logic             cmd_write_o,
    output logic [7:0]       cmd_code_o,
    output logic             cmd_page_o,
    output logic [15:0]      cmd_wdata_o,
    output logic             got_rd_o,
    output logic             got_nak_o,
    output logic [15:0]      got_data_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_page_o  = 1'b0;
        cmd_wdata_o = 16'h0000;
    end

    // Held until the next call or release_bus; answer is sampled where it stands, one cycle later
    task issue(input logic w, input logic [7:0] code, input logic pg,
               input logic [15:0] data);
        cmd_valid_o = 1'b1;
        cmd_write_o = w;
        cmd_code_o  = code;
        cmd_page_o  = pg;
        cmd_wdata_o = data;
        @(negedge clock_i);
        got_rd_o   = rd_valid_i;
        got_nak_o  = nak_i;
        got_data_o = rd_data_i;
    endtask : issue

    // Rise and fall changes are followed by a commit; off-delay writes apply without one
    task commit();
        issue(1'b1, CODE_COMMIT, 1'b0, 16'h0000);
    endtask : commit

    // Released write, code and data lines show inverted values so stale commands cannot match
    task release_bus();
        cmd_valid_o = 1'b0;
        cmd_write_o = ~cmd_write_o;
        cmd_code_o  = ~cmd_code_o;
        cmd_wdata_o = ~cmd_wdata_o;
        @(negedge clock_i);
    endtask : release_bus
endmodule : host_cmd_model

// File: testbench/ramp_timing_and_fault_summary_test.sv
// Self-checking bench for the ramp timing and fault summary registers.
// Assumes NOUT of 2, so the page select is one bit wide.
`timescale 1ns/100ps
module ramp_timing_and_fault_summary_test;
    import ramp_fault_pkg::*;
    logic             clock_i = 1'b0;
    logic             rst_i   = 1'b1;
    logic             cmd_valid, cmd_write, cmd_page, got_rd, got_nak;
    logic [7:0]       cmd_code, in_st, temp_st, cml_ext, mfr_st, cml_st;
    logic [15:0]      cmd_wdata, got_data, rd_data, sword;
    logic [1:0][7:0]  vout_st, iout_st;
    logic [1:0]       p_off, p_good;
    logic             other, rd_valid, nak, commit, alert, twarn;
    logic [1:0][15:0] rise, delay, fall;
    logic [7:0]       sbyte;
    logic [15:0]      w;
    int               n_mismatch = 0;
    int               n_checks   = 0;
    logic [15:0]      exp_word [10] = '{16'h8020, 16'h8000, 16'h4010,
        16'h2008, 16'h0004, 16'h0002, 16'h1000, 16'h0800, 16'h0040, 16'h0001};

    always #5 clock_i = ~clock_i;

    ramp_fault_regs #(.NOUT(2)) i_ramp_fault_regs (.clock_i(clock_i),
        .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_code_i(cmd_code), .cmd_page_i(cmd_page),
        .cmd_wdata_i(cmd_wdata), .vout_status_i(vout_st),
        .iout_status_i(iout_st), .input_status_i(in_st),
        .temp_status_i(temp_st), .cml_ext_i(cml_ext), .mfr_status_i(mfr_st),
        .power_off_i(p_off), .power_good_i(p_good), .other_event_i(other),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .nak_o(nak),
        .commit_o(commit), .rise_time_o(rise), .off_delay_o(delay),
        .fall_time_o(fall), .cml_status_o(cml_st), .status_byte_o(sbyte),
        .status_word_o(sword), .alert_o(alert), .temp_warn_o(twarn));

    host_cmd_model i_host_cmd_model (.clock_i(clock_i),
        .rd_valid_i(rd_valid), .rd_data_i(rd_data), .nak_i(nak),
        .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
        .cmd_code_o(cmd_code), .cmd_page_o(cmd_page),
        .cmd_wdata_o(cmd_wdata), .got_rd_o(got_rd), .got_nak_o(got_nak),
        .got_data_o(got_data));

    task check(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task report_and_stop();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task cmd(input logic wr, input logic [7:0] c, input logic pg,
             input logic [15:0] d);
        i_host_cmd_model.issue(wr, c, pg, d);
    endtask : cmd

    // Quiet baseline: both outputs on and good, no faults
    task clear_status();
        vout_st = '0;
        iout_st = '0;
        in_st   = 8'h00;
        temp_st = 8'h00;
        cml_ext = 8'h00;
        mfr_st  = 8'h00;
        p_off   = 2'b00;
        p_good  = 2'b11;
        other   = 1'b0;
    endtask : clear_status

    // Generous bound; the sequence needs about a hundred cycles
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        clear_status();
        repeat (10) @(negedge clock_i);
        rst_i = 1'b0;
        @(negedge clock_i);
        for (int p = 0; p < 2; p++) begin
            check("rise_rst", rise[p], 16'h01F4);
            check("delay_rst", delay[p], 16'h0000);
            check("fall_rst", fall[p], 16'h01F4);
        end
        cmd(1'b0, CODE_FALL, 1'b1, 16'h0000);
        check("rd_fall", got_data, 16'h01F4);
        check("rd_valid", got_rd, 16'h0001);
        // Boundary values written back to back, the rise value read back, then one commit for both
        cmd(1'b1, CODE_RISE, 1'b1, 16'h2710);
        cmd(1'b1, CODE_FALL, 1'b0, 16'h0000);
        check("rise_held", rise[1], 16'h01F4);
        cmd(1'b0, CODE_RISE, 1'b1, 16'h0000);
        check("rd_pend", got_data, 16'h2710);
        check("fall_held", fall[0], 16'h01F4);
        i_host_cmd_model.commit();
        check("commit", commit, 16'h0001);
        check("rise_new", rise[1], 16'h2710);
        check("fall_new", fall[0], 16'h0000);
        cmd(1'b1, CODE_OFF_DELAY, 1'b0, 16'h2710);
        check("delay_new", delay[0], 16'h2710);
        cmd(1'b1, CODE_RISE, 1'b0, 16'h2711);
        check("nak_rise", got_nak, 16'h0001);
        cmd(1'b1, CODE_OFF_DELAY, 1'b1, 16'h2711);
        check("nak_delay", got_nak, 16'h0001);
        cmd(1'b1, CODE_FALL, 1'b1, 16'h2711);
        check("nak_fall", got_nak, 16'h0001);
        cmd(1'b0, CODE_RISE, 1'b0, 16'h0000);
        check("rd_kept", got_data, 16'h01F4);
        // Refusals above left sticky bad-data; clear before the status sweep
        cmd(1'b1, CODE_CLEAR_FAULTS, 1'b0, 16'h0000);
        i_host_cmd_model.release_bus();
        // One detailed source at a time, across both outputs
        for (int k = 0; k < 10; k++) begin
            case (k)
                0: vout_st[1][7] = 1'b1;
                1: vout_st[0][3] = 1'b1;
                2: iout_st[0][7] = 1'b1;
                3: in_st[4] = 1'b1;
                4: temp_st[6] = 1'b1;
                5: cml_ext[0] = 1'b1;
                6: mfr_st[1] = 1'b1;
                7: p_good = 2'b10;
                8: p_off = 2'b01;
                default: other = 1'b1;
            endcase
            w = exp_word[k];
            repeat (3) @(negedge clock_i);
            check("word", sword, w);
            check("byte", {8'h00, sbyte}, {8'h00, w[7:0]});
            check("alert", alert, 16'((w & 16'hFFBF) != 16'h0000));
            check("twarn", twarn, 16'(k == 4));
            cmd(1'b0, CODE_SUM_FULL, 1'b0, 16'h0000);
            check("rd_word", got_data, w);
            cmd(1'b0, CODE_SUM_SHORT, 1'b0, 16'h0000);
            check("rd_byte", got_data, {8'h00, w[7:0]});
            i_host_cmd_model.release_bus();
            clear_status();
            @(negedge clock_i);
        end
        cmd(1'b0, 8'h62, 1'b0, 16'h0000);
        check("nak_code", got_nak, 16'h0001);
        i_host_cmd_model.release_bus();
        repeat (2) @(negedge clock_i);
        check("cml_bad", {8'h00, cml_st}, 16'h0080);
        check("byte_cml", {8'h00, sbyte}, 16'h0002);
        cmd(1'b1, CODE_SUM_SHORT, 1'b0, 16'hFFFF);
        check("ro_nak", got_nak, 16'h0000);
        check("ro_rd", got_rd, 16'h0000);
        cmd(1'b1, CODE_SUM_FULL, 1'b0, 16'hFFFF);
        check("ro_nak_w", got_nak, 16'h0000);
        cmd(1'b0, CODE_SUM_FULL, 1'b0, 16'h0000);
        check("ro_kept", got_data, 16'h0002);
        cmd(1'b1, CODE_CLEAR_FAULTS, 1'b0, 16'h0000);
        i_host_cmd_model.release_bus();
        repeat (3) @(negedge clock_i);
        check("cleared", sword, 16'h0000);
        report_and_stop();
    end
endmodule : ramp_timing_and_fault_summary_test
